// File: twst_map.svh
`ifndef TWST_MAP_SVH
`define TWST_MAP_SVH
`define TWST_ST_OWN_READ 8'ha8
`define TWST_ST_ARB_READ 8'hb0
`define TWST_ST_DATA_ACK 8'hb8
`define TWST_ST_DATA_NACK 8'hc0
`define TWST_ST_LAST_ACK 8'hc8
`define TWST_ST_NO_INFO 8'hf8
`define TWST_ST_BUS_ERR 8'h00
`define TWST_CLK_PERIOD_NS 10
`define TWST_START_HOLD_NS 4000
`define TWST_START_HOLD_CYC \
   ((`TWST_START_HOLD_NS + `TWST_CLK_PERIOD_NS - 1) / `TWST_CLK_PERIOD_NS)
`define TWST_ADDR_BITS 4'h8
`define TWST_LAST_BIT 4'h7
`define TWST_RESET_BYTE 8'h00
`endif

// File: twst_pkg.sv
package twst_pkg;
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_TX_BIT,
      ST_TX_ACK,
      ST_WAIT_SW,
      ST_BUS_ERR,
      ST_GEN_START,
      ST_MASTER_HOLD
   } twst_state_t;
   typedef logic [7:0] twst_byte_t;
endpackage

// File: twst_sync.sv
module twst_sync
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Asynchronous lines in, synchronised lines out
   input wire logic [1:0] raw_i,
   output logic [1:0] sync_o
);
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_bit
         logic meta_reg;
         logic sync_reg;
         // Released lines idle high, so reset to one avoids false edges
         always_ff @(posedge sys_clk_i)
         begin
            if (sys_rst_i)
            begin
               meta_reg <= 1'b1;
               sync_reg <= 1'b1;
            end
            else
            begin
               meta_reg <= raw_i[gi];
               sync_reg <= meta_reg;
            end
         end
         assign sync_o[gi] = sync_reg;
      end
   endgenerate
endmodule

// File: twst_slave_tx.sv
`include "twst_map.svh"

module twst_slave_tx
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe_o,
   output logic sda_o,
   output logic sda_oe_o,
   // Control write
   input wire logic ctrl_wr_i,
   input wire logic ctrl_step_done_i,
   input wire logic ctrl_ack_enable_i,
   input wire logic ctrl_start_i,
   input wire logic ctrl_stop_i,
   // Data and address writes
   input wire logic data_wr_i,
   input wire logic [7:0] data_i,
   input wire logic addr_wr_i,
   input wire logic [7:0] addr_i,
   // Master logic event
   input wire logic arb_lost_i,
   // Status
   output logic step_done_o,
   output logic ack_enable_o,
   output logic start_request_o,
   output logic stop_request_o,
   output logic general_call_enable_o,
   output logic [7:0] status_o,
   output logic [7:0] data_o
);
   twst_pkg::twst_state_t state_reg, state_next;
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   twst_pkg::twst_byte_t shift_reg, shift_next;
   twst_pkg::twst_byte_t rx_reg, rx_next;
   twst_pkg::twst_byte_t serial_data_reg, serial_data_next;
   twst_pkg::twst_byte_t own_address_reg, own_address_next;
   twst_pkg::twst_byte_t code_reg, code_next;
   twst_pkg::twst_byte_t status_reg, status_next;
   logic step_done_reg, step_done_next;
   logic ack_en_reg, ack_en_next;
   logic start_req_reg, start_req_next;
   logic stop_req_reg, stop_req_next;
   logic last_reg, last_next;
   logic ack_seen_reg, ack_seen_next;
   logic lost_reg, lost_next;
   logic busy_reg, busy_next;
   logic [8:0] hold_reg, hold_next;
   logic sda_oe_reg, sda_oe_next;
   logic scl_oe_reg, scl_oe_next;
   logic scl_d_reg, sda_d_reg;
   logic [1:0] line_s;
   logic scl_s, sda_s;
   logic scl_rise, scl_fall, start_ev, stop_ev, in_frame, bus_err;
   logic sw_clear, addr_match;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   twst_sync u_sync
   (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .raw_i({scl_i, sda_i}),
      .sync_o(line_s)
   );

   assign scl_s = line_s[1];
   assign sda_s = line_s[0];
   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_ev = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   assign sw_clear = ctrl_wr_i & ctrl_step_done_i;
   // General call is write only, so it never selects transmit here
   assign addr_match = (rx_reg[7:1] == own_address_reg[7:1]) &
                       rx_reg[0];
   // A repeated START before the first address bit is legal
   assign in_frame = ((state_reg == twst_pkg::ST_ADDR) &&
                      (bit_cnt_reg != 4'h0)) ||
                     (state_reg == twst_pkg::ST_ADDR_ACK) ||
                     (state_reg == twst_pkg::ST_TX_BIT) ||
                     (state_reg == twst_pkg::ST_TX_ACK);
   assign bus_err = in_frame & (start_ev | stop_ev);

   always_comb
   begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      rx_next = rx_reg;
      code_next = code_reg;
      last_next = last_reg;
      ack_seen_next = ack_seen_reg;
      hold_next = hold_reg;
      sda_oe_next = sda_oe_reg;
      scl_oe_next = scl_oe_reg;
      serial_data_next = data_wr_i ? data_i : serial_data_reg;
      own_address_next = addr_wr_i ? addr_i : own_address_reg;
      ack_en_next = ctrl_wr_i ? ctrl_ack_enable_i : ack_en_reg;
      start_req_next = ctrl_wr_i ? ctrl_start_i : start_req_reg;
      stop_req_next = ctrl_wr_i ? ctrl_stop_i : stop_req_reg;
      step_done_next = step_done_reg & ~sw_clear;
      lost_next = lost_reg | arb_lost_i;
      busy_next = (busy_reg | start_ev) & ~stop_ev;
      if (bus_err)
      begin
         // Set below wins over a clear written in the same cycle
         state_next = twst_pkg::ST_BUS_ERR;
         code_next = `TWST_ST_BUS_ERR;
         step_done_next = 1'b1;
         sda_oe_next = 1'b0;
         scl_oe_next = 1'b0;
      end
      else
      begin
         case (state_reg)
            twst_pkg::ST_IDLE:
            begin
               sda_oe_next = 1'b0;
               scl_oe_next = 1'b0;
               if (start_ev)
               begin
                  state_next = twst_pkg::ST_ADDR;
                  bit_cnt_next = 4'h0;
               end
               else if (start_req_reg && !busy_reg && scl_s && sda_s)
               begin
                  state_next = twst_pkg::ST_GEN_START;
                  sda_oe_next = 1'b1;
                  hold_next = 9'(`TWST_START_HOLD_CYC - 1);
               end
            end
            twst_pkg::ST_ADDR:
            begin
               if (start_ev)
                  bit_cnt_next = 4'h0;
               else if (stop_ev)
                  state_next = twst_pkg::ST_IDLE;
               else if (scl_rise)
               begin
                  rx_next = {rx_reg[6:0], sda_s};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end
               else if (scl_fall && bit_cnt_reg == `TWST_ADDR_BITS)
               begin
                  // Address recognition only while ack is enabled
                  if (addr_match && ack_en_reg)
                  begin
                     state_next = twst_pkg::ST_ADDR_ACK;
                     sda_oe_next = 1'b1;
                  end
                  else
                     state_next = twst_pkg::ST_IDLE;
               end
            end
            twst_pkg::ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  state_next = twst_pkg::ST_WAIT_SW;
                  sda_oe_next = 1'b0;
                  scl_oe_next = 1'b1;
                  step_done_next = 1'b1;
                  code_next = lost_reg ? `TWST_ST_ARB_READ :
                              `TWST_ST_OWN_READ;
                  lost_next = 1'b0;
               end
            end
            twst_pkg::ST_TX_BIT:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt_reg == `TWST_LAST_BIT)
                  begin
                     state_next = twst_pkg::ST_TX_ACK;
                     sda_oe_next = 1'b0;
                  end
                  else
                  begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     bit_cnt_next = bit_cnt_reg + 4'h1;
                     sda_oe_next = ~shift_reg[6];
                  end
               end
            end
            twst_pkg::ST_TX_ACK:
            begin
               if (scl_rise)
                  ack_seen_next = ~sda_s;
               else if (scl_fall)
               begin
                  state_next = twst_pkg::ST_WAIT_SW;
                  scl_oe_next = 1'b1;
                  step_done_next = 1'b1;
                  if (!ack_seen_reg)
                     code_next = `TWST_ST_DATA_NACK;
                  else if (last_reg)
                     code_next = `TWST_ST_LAST_ACK;
                  else
                     code_next = `TWST_ST_DATA_ACK;
               end
            end
            twst_pkg::ST_WAIT_SW:
            begin
               // SCL stays low until software writes the flag
               scl_oe_next = 1'b1;
               if (step_done_reg && sw_clear)
               begin
                  scl_oe_next = 1'b0;
                  if (code_reg == `TWST_ST_DATA_NACK ||
                      code_reg == `TWST_ST_LAST_ACK)
                     // Master may keep clocking; it reads ones
                     state_next = twst_pkg::ST_IDLE;
                  else
                  begin
                     state_next = twst_pkg::ST_TX_BIT;
                     shift_next = serial_data_reg;
                     bit_cnt_next = 4'h0;
                     sda_oe_next = ~serial_data_reg[7];
                     ack_seen_next = 1'b0;
                     last_next = ~ctrl_ack_enable_i;
                  end
               end
            end
            twst_pkg::ST_BUS_ERR:
            begin
               sda_oe_next = 1'b0;
               scl_oe_next = 1'b0;
               // Flag may already be cleared; recovery must still work
               if (sw_clear && ctrl_stop_i)
               begin
                  state_next = twst_pkg::ST_IDLE;
                  stop_req_next = 1'b0;
                  busy_next = 1'b0;
               end
            end
            twst_pkg::ST_GEN_START:
            begin
               if (hold_reg == 9'h000)
               begin
                  state_next = twst_pkg::ST_MASTER_HOLD;
                  scl_oe_next = 1'b1;
                  start_req_next = 1'b0;
               end
               else
                  hold_next = hold_reg - 9'h001;
            end
            twst_pkg::ST_MASTER_HOLD:
            begin
               // Master logic owns the bus from here on
               if (ctrl_wr_i || arb_lost_i)
               begin
                  state_next = twst_pkg::ST_IDLE;
                  sda_oe_next = 1'b0;
                  scl_oe_next = 1'b0;
               end
            end
            default:
            begin
               state_next = twst_pkg::ST_IDLE;
               sda_oe_next = 1'b0;
               scl_oe_next = 1'b0;
            end
         endcase
      end
      // Low three bits of every code are zero, so nothing to mask
      status_next = step_done_next ? code_next :
                    `TWST_ST_NO_INFO;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         state_reg <= twst_pkg::ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= `TWST_RESET_BYTE;
         rx_reg <= `TWST_RESET_BYTE;
         serial_data_reg <= `TWST_RESET_BYTE;
         own_address_reg <= `TWST_RESET_BYTE;
         code_reg <= `TWST_ST_NO_INFO;
         status_reg <= `TWST_ST_NO_INFO;
         step_done_reg <= 1'b0;
         ack_en_reg <= 1'b0;
         start_req_reg <= 1'b0;
         stop_req_reg <= 1'b0;
         last_reg <= 1'b0;
         ack_seen_reg <= 1'b0;
         lost_reg <= 1'b0;
         busy_reg <= 1'b0;
         hold_reg <= 9'h000;
         sda_oe_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         rx_reg <= rx_next;
         serial_data_reg <= serial_data_next;
         own_address_reg <= own_address_next;
         code_reg <= code_next;
         status_reg <= status_next;
         step_done_reg <= step_done_next;
         ack_en_reg <= ack_en_next;
         start_req_reg <= start_req_next;
         stop_req_reg <= stop_req_next;
         last_reg <= last_next;
         ack_seen_reg <= ack_seen_next;
         lost_reg <= lost_next;
         busy_reg <= busy_next;
         hold_reg <= hold_next;
         sda_oe_reg <= sda_oe_next;
         scl_oe_reg <= scl_oe_next;
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = scl_oe_reg;
   assign sda_oe_o = sda_oe_reg;
   assign step_done_o = step_done_reg;
   assign ack_enable_o = ack_en_reg;
   assign start_request_o = start_req_reg;
   assign stop_request_o = stop_req_reg;
   assign general_call_enable_o = own_address_reg[0];
   assign status_o = status_reg;
   assign data_o = serial_data_reg;

   a_no_info: assert property (
      !step_done_o |-> status_o == `TWST_ST_NO_INFO)
      else $error("status not F8 while flag low");
   a_low_bits: assert property (
      status_o[2:0] == 3'h0)
      else $error("status low bits not zero");
   a_scl_hold: assert property (
      (state_reg == twst_pkg::ST_WAIT_SW) && step_done_o && !ctrl_wr_i
      |=> scl_oe_o && step_done_o)
      else $error("SCL not held while flag set");
   a_own_read: assert property (
      (state_reg == twst_pkg::ST_ADDR_ACK) && scl_fall && !bus_err && !lost_reg
      |=> step_done_o && status_o == `TWST_ST_OWN_READ)
      else $error("A8 not reported");
   a_arb_read: assert property (
      (state_reg == twst_pkg::ST_ADDR_ACK) && scl_fall && !bus_err && lost_reg
      |=> step_done_o && status_o == `TWST_ST_ARB_READ)
      else $error("B0 not reported");
   a_ack_codes: assert property (
      (state_reg == twst_pkg::ST_TX_ACK) && scl_fall && !bus_err
      |=> step_done_o && status_o == ($past(ack_seen_reg) ?
          ($past(last_reg) ? `TWST_ST_LAST_ACK : `TWST_ST_DATA_ACK) :
          `TWST_ST_DATA_NACK))
      else $error("wrong code after acknowledge bit");
   a_last_flag: assert property (
      (state_reg == twst_pkg::ST_WAIT_SW) && step_done_o && sw_clear &&
      (code_reg == `TWST_ST_DATA_ACK || code_reg == `TWST_ST_OWN_READ ||
       code_reg == `TWST_ST_ARB_READ) && !bus_err
      |=> (state_reg == twst_pkg::ST_TX_BIT) && !scl_oe_o &&
          last_reg == !$past(ctrl_ack_enable_i))
      else $error("byte load did not follow ack enable");
   a_end_idle: assert property (
      (state_reg == twst_pkg::ST_WAIT_SW) && step_done_o && sw_clear &&
      (code_reg == `TWST_ST_DATA_NACK || code_reg == `TWST_ST_LAST_ACK)
      |=> state_reg == twst_pkg::ST_IDLE && ack_enable_o ==
          $past(ctrl_ack_enable_i) && start_request_o == $past(ctrl_start_i))
      else $error("not addressed mode not entered");
   a_bus_error: assert property (
      bus_err |=> step_done_o && status_o == `TWST_ST_BUS_ERR &&
      !sda_oe_o && !scl_oe_o)
      else $error("bus error not reported");
   a_recover: assert property (
      (state_reg == twst_pkg::ST_BUS_ERR) && step_done_o && sw_clear &&
      ctrl_stop_i |=> state_reg == twst_pkg::ST_IDLE && !stop_request_o
      ##1 (!sda_oe_o && !scl_oe_o)[*2])
      else $error("bus error recovery failed");
   a_start_gen: assert property (
      (state_reg == twst_pkg::ST_IDLE) && start_request_o && !busy_reg &&
      scl_s && sda_s && !start_ev |=> sda_oe_o && !scl_oe_o)
      else $error("START not driven on free bus");

   c_own_read: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      status_o == `TWST_ST_OWN_READ);
   c_data_nack: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      status_o == `TWST_ST_DATA_NACK);
   c_last_ack: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      status_o == `TWST_ST_LAST_ACK);
   c_bus_err: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      step_done_o && status_o == `TWST_ST_BUS_ERR);
endmodule

// File: twst_master_model.sv
module twst_master_model
(
   // Wire levels as seen on the bus
   input wire logic scl_i,
   input wire logic sda_i,
   // Pull requests, high pulls the line low
   output logic scl_pull_o,
   output logic sda_pull_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int stuck = 0;
   initial
   begin
      scl_pull_o = 1'b0;
      sda_pull_o = 1'b0;
   end
   // One SCL clock; SCL stands still between frames
   task automatic clk_bit(input logic b, output logic s);
      int k;
      sda_pull_o = ~b;
      #30;
      scl_pull_o = 1'b0;
      k = 0;
      // Wait while the slave stretches the low phase
      while (scl_i !== 1'b1 && k < 2000)
      begin
         #10;
         k++;
      end
      if (k == 2000) stuck++;
      #31 s = sda_i;
      #31 scl_pull_o = 1'b1;
      #32;
   endtask
   task automatic start();
      sda_pull_o = 1'b0;
      scl_pull_o = 1'b0;
      #60 sda_pull_o = 1'b1;
      #60 scl_pull_o = 1'b1;
      #30;
   endtask
   task automatic stop();
      sda_pull_o = 1'b1;
      #30 scl_pull_o = 1'b0;
      #60 sda_pull_o = 1'b0;
      #60;
   endtask
   task automatic send_addr(input logic [7:0] a, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(a[i], s);
      clk_bit(1'b1, s);
      acked = ~s;
   endtask
   // Receiver answers each byte; released SDA reads as 1 by pull-up
   task automatic read_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(~ack, s);
      #20 sda_pull_o = 1'b0;
   endtask
endmodule

// File: tb.sv
`include "twst_map.svh"
`define CHK(got, exp) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); \
      end \
   end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0, sys_rst = 1'b1, ctrl_wr = 1'b0, ctrl_step = 1'b0;
   logic ctrl_ack = 1'b0, ctrl_sta = 1'b0, ctrl_sto = 1'b0;
   logic data_wr = 1'b0, addr_wr = 1'b0, arb_lost = 1'b0;
   logic [7:0] data = 8'h00, addr = 8'h00, d, status, dout;
   logic scl, sda, scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, ok;
   logic step_done, ack_en, sta_req, sto_req, gce;
   int failures = 0, n_compared = 0, cycles = 0, n;
   time t_sda = 0, t_scl = 0;
   // Open-drain wires with pull-ups
   assign scl = (scl_oe ? scl_o : 1'b1) & ~m_scl;
   assign sda = (sda_oe ? sda_o : 1'b1) & ~m_sda;
   always #5 sys_clk = ~sys_clk;
   // Latest rise of each pull, to time the START hold exactly
   always @(posedge sda_oe) t_sda = $time;
   always @(posedge scl_oe) t_scl = $time;
   twst_slave_tx twst_slave_tx_i (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
      .scl_i(scl), .sda_i(sda), .scl_o(scl_o), .scl_oe_o(scl_oe),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .ctrl_wr_i(ctrl_wr),
      .ctrl_step_done_i(ctrl_step), .ctrl_ack_enable_i(ctrl_ack),
      .ctrl_start_i(ctrl_sta), .ctrl_stop_i(ctrl_sto), .data_wr_i(data_wr),
      .data_i(data), .addr_wr_i(addr_wr), .addr_i(addr),
      .arb_lost_i(arb_lost), .step_done_o(step_done),
      .ack_enable_o(ack_en), .start_request_o(sta_req),
      .stop_request_o(sto_req), .general_call_enable_o(gce),
      .status_o(status), .data_o(dout));
   twst_master_model twst_master_model_i (.scl_i(scl), .sda_i(sda),
      .scl_pull_o(m_scl), .sda_pull_o(m_sda));
   task automatic summarize();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Generous ceiling; the tests need well under 15000 cycles
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         failures++;
         summarize();
      end
   end
   task automatic wr_ctrl(input logic s, a, st, sp);
      @(negedge sys_clk);
      ctrl_wr = 1'b1;
      ctrl_step = s;
      ctrl_ack = a;
      ctrl_sta = st;
      ctrl_sto = sp;
      @(negedge sys_clk);
      ctrl_wr = 1'b0;
   endtask
   task automatic wr_reg(input logic is_addr, input logic [7:0] v);
      @(negedge sys_clk);
      data_wr = ~is_addr;
      addr_wr = is_addr;
      data = v;
      addr = v;
      @(negedge sys_clk);
      data_wr = 1'b0;
      addr_wr = 1'b0;
   endtask
   task automatic settle();
      repeat (6) @(negedge sys_clk);
   endtask
   task automatic test_done(input string name);
      $display("test %s done", name);
   endtask
   // Frame start plus own address with read, then status check
   task automatic open_read(input logic exp_ack, input logic [7:0] code);
      twst_master_model_i.start();
      twst_master_model_i.send_addr(8'ha5, ok);
      settle();
      `CHK(ok, exp_ack)
      if (exp_ack)
      begin
         `CHK(status, code)
         `CHK(step_done, 1'b1)
      end
   endtask
   initial
   begin
      repeat (12) @(negedge sys_clk);
      sys_rst = 1'b0;
      `CHK({status, step_done, scl_oe, sda_oe, dout}, 19'h7c000)
      wr_reg(1'b1, 8'ha5);
      wr_ctrl(1'b0, 1'b1, 1'b0, 1'b0);
      `CHK({gce, ack_en}, 2'b11)
      twst_master_model_i.start();
      twst_master_model_i.send_addr(8'ha7, ok);
      `CHK(ok, 1'b0)
      twst_master_model_i.stop();
      test_done("reset_and_address");
      open_read(1'b1, 8'ha8);
      repeat (20) @(negedge sys_clk);
      `CHK({scl_oe, scl}, 2'b10)
      // Data byte loaded while A8 is read
      wr_reg(1'b0, 8'h96);
      `CHK(dout, 8'h96)
      wr_ctrl(1'b1, 1'b1, 1'b0, 1'b0);
      settle();
      `CHK({status, step_done}, 9'h1f0)
      twst_master_model_i.read_byte(1'b1, d);
      settle();
      `CHK(d, 8'h96)
      `CHK(status, 8'hb8)
      wr_reg(1'b0, 8'h3c);
      wr_ctrl(1'b1, 1'b0, 1'b0, 1'b0);
      twst_master_model_i.read_byte(1'b1, d);
      settle();
      `CHK(d, 8'h3c)
      `CHK(status, 8'hc8)
      wr_ctrl(1'b1, 1'b1, 1'b0, 1'b0);
      twst_master_model_i.read_byte(1'b0, d);
      `CHK(d, 8'hff)
      twst_master_model_i.stop();
      test_done("ack_then_last_acked");
      open_read(1'b1, 8'ha8);
      wr_reg(1'b0, 8'h81);
      wr_ctrl(1'b1, 1'b0, 1'b0, 1'b0);
      twst_master_model_i.read_byte(1'b0, d);
      settle();
      `CHK(d, 8'h81)
      `CHK(status, 8'hc0)
      wr_ctrl(1'b1, 1'b0, 1'b0, 1'b0);
      twst_master_model_i.stop();
      open_read(1'b0, 8'h00);
      twst_master_model_i.stop();
      test_done("nack_and_ignore");
      wr_ctrl(1'b0, 1'b1, 1'b0, 1'b0);
      twst_master_model_i.start();
      for (int i = 0; i < 3; i++) twst_master_model_i.clk_bit(1'b1, ok);
      twst_master_model_i.stop();
      settle();
      `CHK({status, step_done}, 9'h001)
      `CHK({scl_oe, sda_oe, scl_o, sda_o}, 4'h0)
      wr_ctrl(1'b1, 1'b1, 1'b0, 1'b1);
      settle();
      `CHK({sto_req, ack_en, step_done, scl_oe, sda_oe}, 5'b01000)
      `CHK(status, 8'hf8)
      test_done("bus_error");
      @(negedge sys_clk);
      arb_lost = 1'b1;
      @(negedge sys_clk);
      arb_lost = 1'b0;
      open_read(1'b1, 8'hb0);
      wr_reg(1'b0, 8'h55);
      wr_ctrl(1'b1, 1'b1, 1'b0, 1'b0);
      twst_master_model_i.read_byte(1'b0, d);
      settle();
      `CHK({d, status}, 16'h55c0)
      wr_ctrl(1'b1, 1'b0, 1'b1, 1'b0);
      repeat (50) @(negedge sys_clk);
      `CHK(sda_oe, 1'b0)
      twst_master_model_i.stop();
      n = 0;
      while (sda_oe !== 1'b1 && n < 200)
      begin
         @(negedge sys_clk);
         n++;
      end
      `CHK(sda_oe, 1'b1)
      n = 0;
      while (scl_oe !== 1'b1 && n < 1000)
      begin
         @(negedge sys_clk);
         n++;
      end
      `CHK(t_scl - t_sda, `TWST_START_HOLD_NS)
      @(negedge sys_clk);
      `CHK({scl_oe, sta_req}, 2'b10)
      wr_ctrl(1'b0, 1'b1, 1'b0, 1'b0);
      settle();
      `CHK({scl_oe, sda_oe}, 2'b00)
      `CHK(twst_master_model_i.stuck, 0)
      test_done("arb_lost_and_start");
      summarize();
   end
endmodule
